// File: core/rxsw_pkg.sv
// package for the receive status word builder: constants, layouts and carrier types
package rxsw_pkg;
    // status frame shape
    localparam int RXSW_WORDS = 6;
    localparam logic [2:0] RXSW_LAST_IDX = 3'h5;
    localparam logic [3:0] RXSW_TAG_FLAG = 4'h5;
    // ethernet constants
    localparam logic [15:0] RXSW_LT_CTRL = 16'h8808;
    localparam logic [15:0] RXSW_LT_VLAN = 16'h8100;
    localparam logic [15:0] RXSW_LT_MAXLEN = 16'h05DC;
    localparam logic [15:0] RXSW_OP_PAUSE = 16'h0001;
    localparam logic [15:0] RXSW_MIN_FRAME = 16'h0040;
    localparam logic [15:0] RXSW_MAX_FRAME = 16'h05EE;
    localparam logic [15:0] RXSW_MAX_VLAN_FRAME = 16'h05F2;
    localparam logic [47:0] RXSW_CTRL_MCAST = 48'h0100_00C2_8001;
    localparam logic [23:0] RXSW_IP_GRP_PREFIX = 24'h5E_0001;
    // word 3 field positions
    localparam int RXSW_B_BAD = 31;
    localparam int RXSW_B_FCS = 30;
    localparam int RXSW_B_BCAST = 29;
    localparam int RXSW_B_MCAST = 28;
    localparam int RXSW_CNT_HI = 27;
    localparam int RXSW_CNT_LO = 14;
    localparam int RXSW_CNT_W = 14;
    localparam int RXSW_B_ALIGN = 13;
    localparam int RXSW_B_LEN = 12;
    localparam int RXSW_B_BADOP = 11;
    localparam int RXSW_B_PAUSE = 10;
    localparam int RXSW_B_VLAN = 9;
    localparam int RXSW_B_OVSZ = 8;
    localparam int RXSW_B_CTRL = 7;
    localparam int RXSW_CS_HI = 5;
    localparam int RXSW_CS_LO = 3;
    localparam int RXSW_B_BCFLG = 2;
    localparam int RXSW_B_IPFLG = 1;
    localparam int RXSW_B_MCFLG = 0;
    // checksum check codes
    localparam logic [2:0] RXSW_CS_NONE = 3'h0;
    localparam logic [2:0] RXSW_CS_IP_OK = 3'h1;
    localparam logic [2:0] RXSW_CS_TCP_OK = 3'h2;
    localparam logic [2:0] RXSW_CS_UDP_OK = 3'h3;
    localparam logic [2:0] RXSW_CS_RSVD = 3'h4;
    localparam logic [2:0] RXSW_CS_IP_BAD = 3'h5;
    localparam logic [2:0] RXSW_CS_TCP_BAD = 3'h6;
    localparam logic [2:0] RXSW_CS_UDP_BAD = 3'h7;
    // register map, byte addresses
    localparam logic [3:0] RXSW_REG_CTRL = 4'h0;
    localparam logic [3:0] RXSW_REG_STA_LO = 4'h4;
    localparam logic [3:0] RXSW_REG_STA_HI = 4'h8;
    localparam logic [3:0] RXSW_REG_STATE = 4'hC;
    localparam logic [3:0] RXSW_CTRL_RST = 4'h4;
    localparam logic [1:0] RXSW_RESP_OKAY = 2'h0;
    localparam logic [1:0] RXSW_RESP_SLVERR = 2'h2;
    // transport protocol seen by the checksum engine
    typedef enum logic [1:0] {RXSW_L4_NONE, RXSW_L4_TCP, RXSW_L4_UDP} rxsw_l4_t;
    // per-frame summary from the receive path
    typedef struct packed {
        logic [47:0] dest_addr;
        logic [15:0] length_type_field;
        logic [15:0] opcode;
        logic [15:0] tci;
        logic [15:0] frame_bytes;
        logic [15:0] data_bytes;
        logic [15:0] raw_csum;
        logic fcs_bad;
        logic phy_err;
        logic nibble_misalign;
        logic padded;
        logic addr_filter_pass;
        logic mcast_filter_pass;
        logic pause_acted;
        logic ip_checked;
        logic ip_ok;
        rxsw_l4_t l4_kind;
        logic l4_ok;
    } rxsw_info_t;
    // control register fields
    typedef struct packed {
        logic nibble_mode;
        logic lt_check_en;
        logic jumbo_en;
        logic vlan_en;
    } rxsw_ctrl_t;
endpackage

// File: core/rxsw_status_word.sv
// receive status frame builder with status stream master and register slave
`timescale 1ns/1ps
module rxsw_status_word
    import rxsw_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_info_valid,
    input wire rxsw_info_t i_info,
    output logic o_info_ready,
    output logic o_sts_tvalid,
    input wire logic i_sts_tready,
    output logic [31:0] o_sts_tdata,
    output logic o_sts_tlast,
    output logic o_data_release,
    input wire logic i_data_done,
    input wire logic [3:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [3:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready
);
    typedef enum logic [1:0] {RXSW_IDLE, RXSW_SEND, RXSW_DATA} rxsw_state_t;

    rxsw_state_t state_q;
    rxsw_ctrl_t ctrl_q;
    logic [47:0] station_q;
    logic [15:0] frame_cnt_q;
    logic [31:0] words_q [RXSW_WORDS];
    logic [2:0] idx_q;
    logic [31:0] w3_d;
    logic info_fire;
    logic sts_fire;
    logic is_ctrl, is_vlan, is_bcast, is_mcast, any_err;
    logic len_err, ovsz_err, fcs_err, align_err;
    logic [15:0] max_len;
    logic [2:0] cs_code;

    assign info_fire = i_ce && i_info_valid && o_info_ready;
    assign sts_fire = i_ce && o_sts_tvalid && i_sts_tready;

    // frame classification from the summary
    always_comb begin
        is_ctrl = i_info.length_type_field == RXSW_LT_CTRL;
        is_vlan = ctrl_q.vlan_en && (i_info.length_type_field == RXSW_LT_VLAN);
        is_bcast = &i_info.dest_addr;
        is_mcast = i_info.dest_addr[0];
        align_err = ctrl_q.nibble_mode && !i_info.fcs_bad && i_info.nibble_misalign;
        len_err = 1'b0;
        if (ctrl_q.lt_check_en && i_info.length_type_field <= RXSW_LT_MAXLEN) begin
            if (i_info.padded) begin
                len_err = i_info.frame_bytes != RXSW_MIN_FRAME;
            end else begin
                len_err = i_info.length_type_field != i_info.data_bytes;
            end
        end
        max_len = is_vlan ? RXSW_MAX_VLAN_FRAME : RXSW_MAX_FRAME;
        ovsz_err = !ctrl_q.jumbo_en && (i_info.frame_bytes > max_len);
        fcs_err = i_info.fcs_bad || i_info.phy_err;
        any_err = align_err || len_err || ovsz_err || fcs_err;
    end

    // checksum result code
    always_comb begin
        cs_code = RXSW_CS_NONE;
        if (i_info.ip_checked) begin
            if (!i_info.ip_ok) begin
                cs_code = RXSW_CS_IP_BAD;
            end else begin
                unique case (i_info.l4_kind)
                    RXSW_L4_NONE: cs_code = RXSW_CS_IP_OK;
                    RXSW_L4_TCP: cs_code = i_info.l4_ok ? RXSW_CS_TCP_OK : RXSW_CS_TCP_BAD;
                    RXSW_L4_UDP: cs_code = i_info.l4_ok ? RXSW_CS_UDP_OK : RXSW_CS_UDP_BAD;
                    default: cs_code = RXSW_CS_NONE;
                endcase
            end
        end
    end

    // word three assembly
    always_comb begin
        w3_d = 32'h0000_0000;
        w3_d[RXSW_B_BAD] = any_err;
        w3_d[RXSW_B_FCS] = fcs_err;
        w3_d[RXSW_B_BCAST] = is_bcast;
        w3_d[RXSW_B_MCAST] = is_mcast;
        if (i_info.frame_bytes[15:RXSW_CNT_W] != 2'h0) begin
            w3_d[RXSW_CNT_HI:RXSW_CNT_LO] = 14'h3FFF;
        end else begin
            w3_d[RXSW_CNT_HI:RXSW_CNT_LO] = i_info.frame_bytes[RXSW_CNT_W-1:0];
        end
        w3_d[RXSW_B_ALIGN] = align_err;
        w3_d[RXSW_B_LEN] = len_err;
        w3_d[RXSW_B_BADOP] = !any_err && is_ctrl && (i_info.opcode != RXSW_OP_PAUSE);
        w3_d[RXSW_B_PAUSE] = !any_err && is_ctrl && (i_info.opcode == RXSW_OP_PAUSE) &&
            (i_info.dest_addr == RXSW_CTRL_MCAST || i_info.dest_addr == station_q) &&
            i_info.pause_acted;
        w3_d[RXSW_B_VLAN] = is_vlan;
        w3_d[RXSW_B_OVSZ] = ovsz_err;
        w3_d[RXSW_B_CTRL] = is_ctrl;
        w3_d[RXSW_CS_HI:RXSW_CS_LO] = cs_code;
        w3_d[RXSW_B_BCFLG] = is_bcast && i_info.addr_filter_pass;
        w3_d[RXSW_B_IPFLG] = is_mcast && i_info.mcast_filter_pass &&
            (i_info.dest_addr[23:0] == RXSW_IP_GRP_PREFIX);
        w3_d[RXSW_B_MCFLG] = is_mcast && !is_bcast && i_info.mcast_filter_pass;
    end

    // capture of all six words per frame
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int i = 0; i < RXSW_WORDS; i++) begin
                words_q[i] <= 32'h0000_0000;
            end
        end else if (info_fire) begin
            words_q[0] <= {RXSW_TAG_FLAG, 28'h000_0000};
            words_q[1] <= {16'h0000, i_info.dest_addr[47:32]};
            words_q[2] <= i_info.dest_addr[31:0];
            words_q[3] <= w3_d;
            words_q[4] <= {i_info.length_type_field, i_info.raw_csum};
            words_q[5] <= {i_info.tci, i_info.frame_bytes};
        end
    end

    // frame sequencer: status stream first, then data release
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_q <= RXSW_IDLE;
            idx_q <= 3'h0;
            o_info_ready <= 1'b1;
            o_sts_tvalid <= 1'b0;
            o_sts_tlast <= 1'b0;
            o_sts_tdata <= 32'h0000_0000;
            o_data_release <= 1'b0;
            frame_cnt_q <= 16'h0000;
        end else if (i_ce) begin
            unique case (state_q)
                RXSW_IDLE: begin
                    if (i_info_valid) begin
                        state_q <= RXSW_SEND;
                        o_info_ready <= 1'b0;
                        o_sts_tvalid <= 1'b1;
                        o_sts_tdata <= {RXSW_TAG_FLAG, 28'h000_0000};
                        o_sts_tlast <= 1'b0;
                        idx_q <= 3'h0;
                    end
                end
                RXSW_SEND: begin
                    if (i_sts_tready) begin
                        if (idx_q == RXSW_LAST_IDX) begin
                            state_q <= RXSW_DATA;
                            o_sts_tvalid <= 1'b0;
                            o_sts_tlast <= 1'b0;
                            o_data_release <= 1'b1;
                        end else begin
                            idx_q <= idx_q + 3'h1;
                            o_sts_tdata <= words_q[idx_q + 3'h1];
                            o_sts_tlast <= (idx_q + 3'h1) == RXSW_LAST_IDX;
                        end
                    end
                end
                RXSW_DATA: begin
                    if (i_data_done) begin
                        state_q <= RXSW_IDLE;
                        o_data_release <= 1'b0;
                        o_info_ready <= 1'b1;
                        frame_cnt_q <= frame_cnt_q + 16'h0001;
                    end
                end
            endcase
        end
    end

    // register slave: write address and data latches
    logic aw_have_q, w_have_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
        end else if (i_ce) begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= i_s_axi_awaddr;
                o_s_axi_awready <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= i_s_axi_wdata;
                w_strb_q <= i_s_axi_wstrb;
                o_s_axi_wready <= 1'b0;
            end
            if (o_s_axi_bvalid && i_s_axi_bready) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                o_s_axi_awready <= 1'b1;
                o_s_axi_wready <= 1'b1;
            end
        end
    end

    // register slave: write commit and response
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_q <= RXSW_CTRL_RST;
            station_q <= 48'h0000_0000_0000;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= RXSW_RESP_OKAY;
        end else if (i_ce) begin
            if (aw_have_q && w_have_q && !o_s_axi_bvalid) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= RXSW_RESP_OKAY;
                unique case (aw_addr_q)
                    RXSW_REG_CTRL: if (w_strb_q[0]) ctrl_q <= w_data_q[3:0];
                    RXSW_REG_STA_LO: begin
                        for (int b = 0; b < 4; b++) begin
                            if (w_strb_q[b]) station_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
                        end
                    end
                    RXSW_REG_STA_HI: begin
                        for (int b = 0; b < 2; b++) begin
                            if (w_strb_q[b]) station_q[32 + b*8 +: 8] <= w_data_q[b*8 +: 8];
                        end
                    end
                    RXSW_REG_STATE: o_s_axi_bresp <= RXSW_RESP_OKAY; // read-only, write ignored
                    default: o_s_axi_bresp <= RXSW_RESP_SLVERR;
                endcase
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register slave: read path, answer one cycle after address
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= RXSW_RESP_OKAY;
        end else if (i_ce) begin
            if (i_s_axi_arvalid && o_s_axi_arready) begin
                o_s_axi_arready <= 1'b0;
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rresp <= RXSW_RESP_OKAY;
                unique case (i_s_axi_araddr)
                    RXSW_REG_CTRL: o_s_axi_rdata <= {28'h000_0000, ctrl_q};
                    RXSW_REG_STA_LO: o_s_axi_rdata <= station_q[31:0];
                    RXSW_REG_STA_HI: o_s_axi_rdata <= {16'h0000, station_q[47:32]};
                    RXSW_REG_STATE: o_s_axi_rdata <= {14'h0000, state_q, frame_cnt_q};
                    default: begin
                        o_s_axi_rdata <= 32'h0000_0000;
                        o_s_axi_rresp <= RXSW_RESP_SLVERR;
                    end
                endcase
            end else if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
                o_s_axi_arready <= 1'b1;
            end
        end
    end

    // checks on the status stream and word contents
    logic w3_beat;
    assign w3_beat = o_sts_tvalid && idx_q == 3'h3;

    tag_first_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        info_fire |=> o_sts_tvalid && o_sts_tdata[31:28] == RXSW_TAG_FLAG && idx_q == 3'h0)
        else $error("first status word lacks tag");
    order_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_data_release |-> !o_sts_tvalid && state_q == RXSW_DATA)
        else $error("data released while status pending");
    release_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        sts_fire && o_sts_tlast |=> o_data_release && !o_sts_tvalid)
        else $error("data not released after last status word");
    hold_beat_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_sts_tvalid && !sts_fire |=> o_sts_tvalid && $stable(o_sts_tdata) && $stable(o_sts_tlast))
        else $error("status beat changed while stalled");
    fresh_word_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        info_fire |=> words_q[3] == $past(w3_d) && words_q[5][15:0] == $past(i_info.frame_bytes))
        else $error("word three not recomputed");
    cs_reserved_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        w3_beat |-> o_sts_tdata[RXSW_CS_HI:RXSW_CS_LO] != RXSW_CS_RSVD)
        else $error("reserved checksum code sent");
    bad_any_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        w3_beat && (o_sts_tdata[RXSW_B_FCS] || o_sts_tdata[RXSW_B_LEN] || o_sts_tdata[RXSW_B_ALIGN] ||
        o_sts_tdata[RXSW_B_OVSZ]) |-> o_sts_tdata[RXSW_B_BAD])
        else $error("error without bad frame flag");
    pause_clean_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        w3_beat && o_sts_tdata[RXSW_B_PAUSE] |-> o_sts_tdata[RXSW_B_CTRL] && !o_sts_tdata[RXSW_B_BAD]
        && !o_sts_tdata[RXSW_B_BADOP])
        else $error("pause flag on bad or non control frame");
    badop_clean_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        w3_beat && o_sts_tdata[RXSW_B_BADOP] |-> o_sts_tdata[RXSW_B_CTRL] && !o_sts_tdata[RXSW_B_BAD])
        else $error("bad opcode flag on bad or non control frame");
    group_flags_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        w3_beat && (o_sts_tdata[RXSW_B_IPFLG] || o_sts_tdata[RXSW_B_MCFLG]) |-> o_sts_tdata[RXSW_B_MCAST])
        else $error("group flag without multicast destination");
    broadcast_passed_flag_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        w3_beat && o_sts_tdata[RXSW_B_BCFLG] |-> o_sts_tdata[RXSW_B_BCAST] && !o_sts_tdata[RXSW_B_MCFLG])
        else $error("broadcast flag inconsistent");
    jumbo_ovsz_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        info_fire && ctrl_q.jumbo_en |=> !words_q[3][RXSW_B_OVSZ])
        else $error("oversize flagged with jumbo enabled");
    align_mode_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        info_fire && !ctrl_q.nibble_mode |=> !words_q[3][RXSW_B_ALIGN])
        else $error("alignment flagged outside nibble mode");

    frame_cov_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        sts_fire && o_sts_tlast ##[1:20] o_data_release && i_data_done);
    stall_cov_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        o_sts_tvalid && !i_sts_tready ##1 sts_fire);
    pause_cov_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        w3_beat && o_sts_tdata[RXSW_B_PAUSE]);
endmodule

// File: sim/rxsw_consumer.sv
// status stream consumer model: optional stalls, data completion pulse
`timescale 1ns/1ps
module rxsw_consumer
    import rxsw_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic i_tvalid,
    input wire logic [31:0] i_tdata,
    input wire logic i_tlast,
    input wire logic i_release,
    output logic o_tready,
    output logic o_done
);
    logic [31:0] words [0:5];
    int cnt;
    int bad;
    logic [1:0] hold_q;
    // take words, stalling every other cycle when slow
    always @(posedge i_mclk) begin
        if (i_rst) begin
            cnt <= 0;
            bad <= 0;
            o_tready <= 1'b0;
        end else begin
            o_tready <= i_slow ? ~o_tready : 1'b1;
            if (i_tvalid && o_tready) begin
                words[cnt % 6] <= i_tdata;
                cnt <= cnt + 1;
            end
            if ((i_tvalid && o_tready && i_tlast !== (cnt % 6 == 5)) || (i_release && cnt % 6 != 0)) begin
                bad <= bad + 1;
            end
        end
    end
    // end the frame data a few cycles after release
    always @(posedge i_mclk) begin
        if (i_rst || !i_release || o_done) begin
            hold_q <= 2'h0;
            o_done <= 1'b0;
        end else begin
            hold_q <= hold_q + 2'h1;
            o_done <= hold_q == 2'h3;
        end
    end
endmodule

// File: sim/rxsw_status_word_tb_top.sv
// testbench for the receive status word builder
`timescale 1ns/1ps
module rxsw_status_word_tb_top
    import rxsw_pkg::*;
;
    logic i_mclk, i_rst, slow, iv, ready, tv, tl, rel, done, tr;
    logic awv, wv, br, arv, rr, awr, wrd, bv, arr, rv;
    logic [3:0] awa, ara, ctl;
    logic [31:0] wd, td, rd;
    logic [1:0] bresp, rresp;
    rxsw_info_t info;
    logic [47:0] sta;
    int errors, total_checks;
    localparam logic [47:0] dst [0:3] = '{48'hFFFF_FFFF_FFFF, 48'h0C0B_0A5E_0001,
        48'h3344_5566_7701, 48'h0605_0403_0200};

    rxsw_status_word i_rxsw_status_word (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1),
        .i_info_valid(iv), .i_info(info), .o_info_ready(ready), .o_sts_tvalid(tv),
        .i_sts_tready(tr), .o_sts_tdata(td), .o_sts_tlast(tl), .o_data_release(rel),
        .i_data_done(done), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
        .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .i_s_axi_araddr(ara),
        .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rv), .i_s_axi_rready(rr));
    rxsw_consumer i_rxsw_consumer (.i_mclk(i_mclk), .i_rst(i_rst), .i_slow(slow), .i_tvalid(tv),
        .i_tdata(td), .i_tlast(tl), .i_release(rel), .o_tready(tr), .o_done(done));

    // 200 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    // hang guard
    initial begin
        #200000;
        errors = errors + 1;
        results();
    end

    task automatic results();
        if (errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // register write, address and data offered together
    task automatic wchk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge i_mclk);
            if (awr === 1'b1 && awv) ta = 1'b1;
            if (ta) awv <= 1'b0;
            if (wrd === 1'b1 && wv) tw = 1'b1;
            if (tw) wv <= 1'b0;
        end
        do @(posedge i_mclk); while (bv !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge i_mclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge i_mclk); while (rv !== 1'b1);
        chk("rdata", ed, rd);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // expected flag word from the frame summary and control bits
    function automatic logic [31:0] w3(rxsw_info_t f);
        logic [31:0] w;
        logic [15:0] lt;
        logic mc, bc, ct, al, ln, ov, fc, ok;
        lt = f.length_type_field;
        w = 32'h0000_0000;
        mc = f.dest_addr[0];
        bc = &f.dest_addr;
        ct = lt == RXSW_LT_CTRL;
        al = ctl[3] && f.nibble_misalign && !f.fcs_bad;
        ln = ctl[2] && lt <= RXSW_LT_MAXLEN && (f.padded ? f.frame_bytes != RXSW_MIN_FRAME : lt != f.data_bytes);
        ov = !ctl[1] && f.frame_bytes > (ctl[0] && lt == RXSW_LT_VLAN ? RXSW_MAX_VLAN_FRAME : RXSW_MAX_FRAME);
        fc = f.fcs_bad || f.phy_err;
        ok = !(al || ln || ov || fc);
        w[RXSW_B_BAD] = !ok;
        w[RXSW_B_FCS] = fc;
        w[RXSW_B_BCAST] = bc;
        w[RXSW_B_MCAST] = mc;
        w[RXSW_CNT_HI:RXSW_CNT_LO] = f.frame_bytes > 16'h3FFF ? 14'h3FFF : f.frame_bytes[13:0];
        w[RXSW_B_ALIGN] = al;
        w[RXSW_B_LEN] = ln;
        w[RXSW_B_BADOP] = ct && ok && f.opcode != RXSW_OP_PAUSE;
        w[RXSW_B_PAUSE] = ct && ok && f.opcode == RXSW_OP_PAUSE && f.pause_acted &&
            (f.dest_addr == RXSW_CTRL_MCAST || f.dest_addr == sta);
        w[RXSW_B_VLAN] = ctl[0] && lt == RXSW_LT_VLAN;
        w[RXSW_B_OVSZ] = ov;
        w[RXSW_B_CTRL] = ct;
        w[RXSW_CS_HI:RXSW_CS_LO] = !f.ip_checked ? RXSW_CS_NONE : !f.ip_ok ? RXSW_CS_IP_BAD :
            f.l4_kind == RXSW_L4_NONE ? RXSW_CS_IP_OK : {!f.l4_ok, f.l4_kind + 2'h1};
        w[RXSW_B_BCFLG] = bc && f.addr_filter_pass;
        w[RXSW_B_IPFLG] = f.dest_addr[23:0] == RXSW_IP_GRP_PREFIX && f.mcast_filter_pass;
        w[RXSW_B_MCFLG] = mc && !bc && f.mcast_filter_pass;
        return w;
    endfunction

    function automatic rxsw_info_t mk(logic [47:0] d, logic [15:0] lt, logic [15:0] fb);
        rxsw_info_t f;
        f = '0;
        f.dest_addr = d;
        f.length_type_field = lt;
        f.frame_bytes = fb;
        f.data_bytes = lt;
        f.tci = 16'hA5C3;
        f.raw_csum = 16'h1234 ^ fb;
        f.addr_filter_pass = 1'b1;
        f.mcast_filter_pass = 1'b1;
        return f;
    endfunction

    // hand one summary over and compare the six status words
    task automatic frame(input rxsw_info_t f);
        logic [31:0] e [0:5];
        e = '{{RXSW_TAG_FLAG, 28'h000_0000}, {16'h0000, f.dest_addr[47:32]}, f.dest_addr[31:0], w3(f),
            {f.length_type_field, f.raw_csum}, {f.tci, f.frame_bytes}};
        info <= f;
        iv <= 1'b1;
        do @(posedge i_mclk); while (ready !== 1'b1);
        iv <= 1'b0;
        do @(posedge i_mclk); while (ready !== 1'b1);
        for (int k = 0; k < 6; k++) chk("status word", e[k], i_rxsw_consumer.words[k]);
    endtask

    initial begin
        rxsw_info_t f;
        errors = 0;
        total_checks = 0;
        {i_rst, slow, iv, awv, wv, br, arv, rr} = 8'h80;
        {awa, ara, wd, sta} = '0;
        info = '0;
        ctl = 4'h4;
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        rchk(RXSW_REG_CTRL, 32'h0000_0004, RXSW_RESP_OKAY);
        // checksum codes, address flags and filter results
        for (int k = 0; k < 9; k++) begin
            f = mk(dst[k % 4], 16'h0800, 16'h0040 + 16'(k));
            f.ip_checked = k != 0;
            f.ip_ok = k != 2;
            f.l4_kind = rxsw_l4_t'(k % 3);
            f.l4_ok = k < 6;
            f.mcast_filter_pass = k < 4;
            f.addr_filter_pass = k != 4;
            slow <= k[0];
            frame(f);
        end
        f = mk(dst[3], 16'h0800, 16'h0050);
        f.fcs_bad = 1'b1;
        frame(f);
        f.fcs_bad = 1'b0;
        f.phy_err = 1'b1;
        frame(f);
        f = mk(dst[3], 16'h002E, 16'h0050);
        f.data_bytes = 16'h0032;
        frame(f);
        f = mk(dst[3], 16'h000A, 16'h0041);
        f.padded = 1'b1;
        frame(f);
        f = mk(RXSW_CTRL_MCAST, RXSW_LT_CTRL, 16'h0040);
        f.opcode = RXSW_OP_PAUSE;
        f.pause_acted = 1'b1;
        frame(f);
        f.opcode = 16'h0002;
        frame(f);
        f.opcode = RXSW_OP_PAUSE;
        f.phy_err = 1'b1;
        frame(f);
        frame(mk(dst[3], 16'h0800, 16'h05EF));
        // vlan, jumbo and nibble mode on, length checks off
        wchk(RXSW_REG_CTRL, 32'h0000_000B, RXSW_RESP_OKAY);
        ctl = 4'hB;
        rchk(RXSW_REG_CTRL, 32'h0000_000B, RXSW_RESP_OKAY);
        f = mk(dst[3], RXSW_LT_VLAN, 16'h4005);
        f.nibble_misalign = 1'b1;
        frame(f);
        f = mk(dst[3], 16'h002E, 16'h0050);
        f.data_bytes = 16'h0010;
        frame(f);
        frame(mk(dst[3], 16'h0800, 16'h0040));
        rchk(RXSW_REG_STATE, 32'h0000_0014, RXSW_RESP_OKAY);
        wchk(RXSW_REG_STATE, 32'h0000_0000, RXSW_RESP_OKAY);
        wchk(RXSW_REG_STA_LO, 32'h0403_0201, RXSW_RESP_OKAY);
        rchk(RXSW_REG_STA_LO, 32'h0403_0201, RXSW_RESP_OKAY);
        wchk(RXSW_REG_STA_HI, 32'h0000_0605, RXSW_RESP_OKAY);
        rchk(RXSW_REG_STA_HI, 32'h0000_0605, RXSW_RESP_OKAY);
        // pause frame addressed to the configured station
        sta = {16'h0605, 32'h0403_0201};
        f = mk(sta, RXSW_LT_CTRL, 16'h0040);
        f.opcode = RXSW_OP_PAUSE;
        f.pause_acted = 1'b1;
        frame(f);
        wchk(4'h2, 32'h0000_0001, RXSW_RESP_SLVERR);
        rchk(4'h2, 32'h0000_0000, RXSW_RESP_SLVERR);
        chk("stream order", 32'h0000_0000, 32'(i_rxsw_consumer.bad));
        results();
    end
endmodule
